// >>> verilog/crf_pkg.sv
`default_nettype none
package crf_pkg;

  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int CRF_DEPTH    = 8;
  localparam int CRF_NPROG    = 6;
  localparam int CRF_NFILT    = 2;
  localparam int CRF_ID_W     = 11;
  localparam int CRF_DLC_W    = 4;
  localparam int CRF_DATA_W   = 64;
  localparam int CRF_ENTRY_W  = CRF_ID_W + CRF_DLC_W + CRF_DATA_W;
  localparam int CRF_IDX_W    = 3;
  localparam int CRF_PTR_W    = 4;
  localparam int CRF_INT_W    = 3;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] CRF_A_STATUS   = 8'h00;
  localparam logic [7:0] CRF_A_CONTROL  = 8'h01;
  localparam logic [7:0] CRF_A_ENHANCED = 8'h02;
  localparam logic [7:0] CRF_A_IOCTRL   = 8'h03;
  localparam logic [7:0] CRF_A_TXSEL    = 8'h04;
  localparam logic [7:0] CRF_A_FULL     = 8'h05;
  localparam logic [7:0] CRF_A_INTSTAT  = 8'h06;
  localparam logic [7:0] CRF_A_INTMASK  = 8'h07;
  localparam logic [7:0] CRF_A_FILTEN   = 8'h08;
  localparam logic [7:0] CRF_A_ID_HI    = 8'h10;
  localparam logic [7:0] CRF_A_ID_LO    = 8'h11;
  localparam logic [7:0] CRF_A_DLC      = 8'h12;
  localparam logic [4:0] CRF_A_DATA_PAGE = 5'h03;
  localparam logic [7:0] CRF_A_FILT_BASE = 8'h20;

  // ***********************************************************
  // field positions and codes
  // ***********************************************************
  localparam int         CRF_MODE_LSB   = 6;
  localparam int         CRF_WMSEL_BIT  = 5;
  localparam int         CRF_CAPSEL_BIT = 4;
  localparam logic [1:0] CRF_MODE_FIFO  = 2'h2;
  localparam logic [4:0] CRF_ICODE_FIFO = 5'h10;
  localparam logic [4:0] CRF_ICODE_NONE = 5'h00;
  localparam int         CRF_INT_RX     = 0;
  localparam int         CRF_INT_WM     = 1;
  localparam int         CRF_INT_OVF    = 2;
  localparam logic [3:0] CRF_WM_ONE     = 4'h1;
  localparam logic [3:0] CRF_WM_FOUR    = 4'h4;
  localparam logic [3:0] CRF_LEN_MIN    = 4'h2;
  localparam logic [3:0] CRF_LEN_MAX    = 4'h8;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [1:0]  CRF_RST_MODE  = 2'h0;
  localparam logic [5:0]  CRF_RST_TXSEL = 6'h00;
  localparam logic [10:0] CRF_RST_ID    = 11'h000;
  localparam logic [7:0]  CRF_RST_BYTE  = 8'h00;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic crf_accept(input logic [10:0] id,
                                      input logic [10:0] filt,
                                      input logic [10:0] mask);
    // a bit passes when unmasked or equal to the filter
    return &(~mask | ~(id ^ filt));
  endfunction : crf_accept

  function automatic logic [3:0] crf_fifo_len(input logic [5:0] tx);
    logic [3:0] len;
    len = CRF_LEN_MAX;
    for (int i = CRF_NPROG - 1; i >= 0; i--) begin
      if (tx[i]) begin
        len = CRF_LEN_MIN + 4'(i);
      end
    end
    return len;
  endfunction : crf_fifo_len

  function automatic logic [2:0] crf_next_ptr(input logic [2:0] p,
                                              input logic [3:0] len);
    if (({1'b0, p} + 4'h1) >= len) begin
      return 3'h0;
    end
    return p + 3'h1;
  endfunction : crf_next_ptr

  function automatic logic [3:0] crf_empty_cnt(input logic [7:0] full,
                                               input logic [3:0] len);
    logic [3:0] cnt;
    cnt = len;
    for (int i = 0; i < CRF_DEPTH; i++) begin
      if ((4'(i) < len) && full[i]) begin
        cnt = cnt - 4'h1;
      end
    end
    return cnt;
  endfunction : crf_empty_cnt

endpackage : crf_pkg
`default_nettype wire

// >>> verilog/crf_msg_mem.sv
`timescale 1ns/1ns
`default_nettype none
module crf_msg_mem
  import crf_pkg::*;
(
  // clock
  input  wire logic                   i_clk,
  // write port
  input  wire logic                   i_we,
  input  wire logic [CRF_IDX_W-1:0]   i_waddr,
  input  wire logic [CRF_ENTRY_W-1:0] i_wdata,
  // read port
  input  wire logic [CRF_IDX_W-1:0]   i_raddr,
  output logic      [CRF_ENTRY_W-1:0] o_rdata
);

  // ***********************************************************
  // storage, one row per buffer, head row first
  // ***********************************************************
  logic [CRF_ENTRY_W-1:0] mem_ff [CRF_DEPTH];
  logic [CRF_ENTRY_W-1:0] rdata_ff;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    rdata_ff <= mem_ff[i_raddr];
  end

  assign o_rdata = rdata_ff;

endmodule : crf_msg_mem
`default_nettype wire

// >>> verilog/crf_rx_fifo.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module crf_rx_fifo
  import crf_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // register port
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  // protocol engine
  input  wire logic                  i_msg_valid,
  input  wire logic [CRF_ID_W-1:0]   i_msg_id,
  input  wire logic [CRF_DLC_W-1:0]  i_msg_dlc,
  input  wire logic [CRF_DATA_W-1:0] i_msg_data,
  // capture unit
  input  wire logic                  i_cap_pin,
  output logic                       o_cap_trigger,
  // status
  output logic                       o_fifo_empty,
  output logic                       o_irq
);

  // ***********************************************************
  // state
  // ***********************************************************
  logic [1:0]           mode_ff;
  logic                 wm_sel_ff;
  logic                 cap_sel_ff;
  logic [5:0]           tx_sel_ff;
  logic [CRF_NFILT-1:0] filt_en_ff;
  logic [10:0]          filt_ff [CRF_NFILT];
  logic [10:0]          mask_ff [CRF_NFILT];
  logic [7:0]           full_ff;
  logic [2:0]           wp_ff;
  logic [2:0]           rp_ff;
  logic [4:0]           icode_ff;
  logic [CRF_INT_W-1:0] int_stat_ff;
  logic [CRF_INT_W-1:0] int_mask_ff;
  logic [7:0]           rdata_ff;
  logic                 cap_strobe_ff;
  logic                 cap_meta_ff;
  logic                 cap_sync_ff;

  logic [7:0]             nxt_full;
  logic [2:0]             nxt_rp;
  logic [2:0]             nxt_wp;
  logic [CRF_INT_W-1:0]   nxt_int_stat;
  logic [4:0]             nxt_icode;
  logic [7:0]             nxt_rdata;
  logic                   fifo_mode;
  logic [3:0]             fifo_len;
  logic [CRF_NFILT-1:0]   filt_hit;
  logic                   hit;
  logic                   store;
  logic                   ovf;
  logic [7:0]             clr_bits;
  logic [7:0]             set_bits;
  logic                   rp_clear;
  logic [3:0]             empty_after;
  logic [3:0]             wm_target;
  logic                   wm_event;
  logic [CRF_INT_W-1:0]   int_set;
  logic [CRF_INT_W-1:0]   int_clr;
  logic [CRF_ENTRY_W-1:0] mem_q;

  // ***********************************************************
  // acceptance and fifo decode
  // ***********************************************************
  assign fifo_mode = (mode_ff == CRF_MODE_FIFO);
  assign fifo_len  = crf_fifo_len(tx_sel_ff);

  always_comb begin
    for (int i = 0; i < CRF_NFILT; i++) begin
      filt_hit[i] = filt_en_ff[i] &
                    crf_accept(i_msg_id, filt_ff[i], mask_ff[i]);
    end
  end

  assign hit   = |filt_hit;
  assign store = i_msg_valid & fifo_mode & hit & ~full_ff[wp_ff];
  assign ovf   = i_msg_valid & fifo_mode & hit & full_ff[wp_ff];

  assign clr_bits = (i_wr && (i_addr == CRF_A_FULL)) ? i_wdata : 8'h00;
  assign set_bits = store ? (8'h01 << wp_ff) : 8'h00;
  // a store in the same cycle as a clear keeps the flag set
  assign nxt_full = (full_ff & ~clr_bits) | set_bits;
  assign rp_clear = clr_bits[rp_ff] & full_ff[rp_ff] & ~set_bits[rp_ff];

  assign nxt_wp = store ? crf_next_ptr(wp_ff, fifo_len) : wp_ff;
  assign nxt_rp = rp_clear ? crf_next_ptr(rp_ff, fifo_len) : rp_ff;

  assign empty_after = crf_empty_cnt(nxt_full, fifo_len);
  assign wm_target   = wm_sel_ff ? CRF_WM_ONE : CRF_WM_FOUR;
  assign wm_event    = store & (empty_after == wm_target);

  // ***********************************************************
  // fifo pointers and full flags
  // ***********************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      full_ff <= 8'h00;
    end else begin
      full_ff <= nxt_full;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_ff <= 3'h0;
      rp_ff <= 3'h0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  crf_msg_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (store),
    .i_waddr (wp_ff),
    .i_wdata ({i_msg_id, i_msg_dlc, i_msg_data}),
    .i_raddr (rp_ff),
    .o_rdata (mem_q)
  );

  // ***********************************************************
  // interrupt code and interrupt flags
  // ***********************************************************
  assign int_set = {ovf, wm_event, store};
  assign int_clr = (i_wr && (i_addr == CRF_A_INTSTAT)) ?
                   i_wdata[CRF_INT_W-1:0] : {CRF_INT_W{1'b0}};
  assign nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;

  always_comb begin
    nxt_icode = icode_ff;
    if (store) begin
      nxt_icode = CRF_ICODE_FIFO;
    end else if (!nxt_int_stat[CRF_INT_RX]) begin
      nxt_icode = CRF_ICODE_NONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      int_stat_ff <= {CRF_INT_W{1'b0}};
      icode_ff    <= CRF_ICODE_NONE;
    end else begin
      int_stat_ff <= nxt_int_stat;
      icode_ff    <= nxt_icode;
    end
  end

  assign o_irq = |(int_stat_ff & int_mask_ff);

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_ff     <= CRF_RST_MODE;
      wm_sel_ff   <= 1'b0;
      cap_sel_ff  <= 1'b0;
      tx_sel_ff   <= CRF_RST_TXSEL;
      int_mask_ff <= {CRF_INT_W{1'b0}};
      filt_en_ff  <= {CRF_NFILT{1'b0}};
    end else if (i_wr) begin
      case (i_addr)
        CRF_A_ENHANCED: begin
          mode_ff   <= i_wdata[CRF_MODE_LSB +: 2];
          wm_sel_ff <= i_wdata[CRF_WMSEL_BIT];
        end
        CRF_A_IOCTRL:  cap_sel_ff  <= i_wdata[CRF_CAPSEL_BIT];
        CRF_A_TXSEL:   tx_sel_ff   <= i_wdata[CRF_NPROG-1:0];
        CRF_A_INTMASK: int_mask_ff <= i_wdata[CRF_INT_W-1:0];
        CRF_A_FILTEN:  filt_en_ff  <= i_wdata[CRF_NFILT-1:0];
        default: begin
        end
      endcase
    end
  end

  // four bytes per filter: filter hi, filter lo, mask hi, mask lo
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CRF_NFILT; i++) begin
        filt_ff[i] <= CRF_RST_ID;
        mask_ff[i] <= CRF_RST_ID;
      end
    end else if (i_wr && (i_addr[7:3] == CRF_A_FILT_BASE[7:3])) begin
      for (int i = 0; i < CRF_NFILT; i++) begin
        if (i_addr[2] == 1'(i)) begin
          case (i_addr[1:0])
            2'h0: filt_ff[i][10:3] <= i_wdata;
            2'h1: filt_ff[i][2:0]  <= i_wdata[2:0];
            2'h2: mask_ff[i][10:3] <= i_wdata;
            2'h3: mask_ff[i][2:0]  <= i_wdata[2:0];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ***********************************************************
  // read data
  // ***********************************************************
  always_comb begin
    nxt_rdata = CRF_RST_BYTE;
    case (i_addr)
      CRF_A_STATUS:   nxt_rdata = {3'h0, icode_ff};
      CRF_A_CONTROL:  nxt_rdata = {4'h0, 1'b0, rp_ff};
      CRF_A_ENHANCED: nxt_rdata = {mode_ff, wm_sel_ff, 5'h00};
      CRF_A_IOCTRL:   nxt_rdata = {3'h0, cap_sel_ff, 4'h0};
      CRF_A_TXSEL:    nxt_rdata = {2'h0, tx_sel_ff};
      CRF_A_FULL:     nxt_rdata = full_ff;
      CRF_A_INTSTAT:  nxt_rdata = {5'h00, int_stat_ff};
      CRF_A_INTMASK:  nxt_rdata = {5'h00, int_mask_ff};
      CRF_A_FILTEN:   nxt_rdata = {6'h00, filt_en_ff};
      CRF_A_ID_HI:    nxt_rdata = mem_q[CRF_ENTRY_W-1 -: 8];
      CRF_A_ID_LO:    nxt_rdata = {mem_q[CRF_ENTRY_W-9 -: 3], 5'h00};
      CRF_A_DLC:      nxt_rdata = {4'h0, mem_q[CRF_DATA_W +: CRF_DLC_W]};
      default: begin
        if (i_addr[7:3] == CRF_A_DATA_PAGE) begin
          nxt_rdata = mem_q[{i_addr[2:0], 3'h0} +: 8];
        end else if (i_addr[7:3] == CRF_A_FILT_BASE[7:3]) begin
          case (i_addr[1:0])
            2'h0: nxt_rdata = filt_ff[i_addr[2]][10:3];
            2'h1: nxt_rdata = {5'h00, filt_ff[i_addr[2]][2:0]};
            2'h2: nxt_rdata = mask_ff[i_addr[2]][10:3];
            default: nxt_rdata = {5'h00, mask_ff[i_addr[2]][2:0]};
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= CRF_RST_BYTE;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= CRF_RST_BYTE;
    end
  end

  assign o_rdata = rdata_ff;

  // ***********************************************************
  // time-stamp capture source
  // ***********************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cap_meta_ff <= 1'b0;
      cap_sync_ff <= 1'b0;
    end else begin
      cap_meta_ff <= i_cap_pin;
      cap_sync_ff <= cap_meta_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cap_strobe_ff <= 1'b0;
    end else begin
      cap_strobe_ff <= store & cap_sel_ff;
    end
  end

  assign o_cap_trigger = cap_sel_ff ? cap_strobe_ff : cap_sync_ff;
  assign o_fifo_empty  = ~full_ff[rp_ff];

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_DEPTH_MAX: assert property (fifo_len <= CRF_LEN_MAX)
    else $error("fifo length above eight");
  AST_NO_FILTER: assert property (
    (i_msg_valid && !hit && !i_wr) |=> $stable(full_ff))
    else $error("unaccepted message changed full flags");
  AST_STORE_FLAG: assert property (
    store |=> full_ff[$past(wp_ff)])
    else $error("stored buffer not flagged full");
  AST_WP_STEP: assert property (
    store |=> wp_ff == crf_next_ptr($past(wp_ff), $past(fifo_len)))
    else $error("write pointer did not step");
  AST_WP_IN_LEN: assert property (
    store |-> ({1'b0, wp_ff} < fifo_len))
    else $error("store outside configured buffers");
  AST_LEN_TWO: assert property (tx_sel_ff[0] |-> fifo_len == 4'h2)
    else $error("first transmit buffer must give length two");
  AST_LEN_FULL: assert property (
    (tx_sel_ff == 6'h00) |-> fifo_len == 4'h8)
    else $error("no transmit buffer must give length eight");
  AST_ICODE: assert property (store |=> icode_ff == 5'h10)
    else $error("interrupt code not loaded");
  AST_RP_HOLD: assert property (!rp_clear |=> $stable(rp_ff))
    else $error("read pointer moved without a clear");
  AST_RP_STEP: assert property (
    rp_clear |=> (rp_ff == crf_next_ptr($past(rp_ff), $past(fifo_len))
                  && !full_ff[$past(rp_ff)]))
    else $error("read pointer did not follow clear");
  AST_EMPTY: assert property ((full_ff == 8'h00) |-> o_fifo_empty)
    else $error("empty not shown with no full buffers");
  AST_WM: assert property (wm_event |=> int_stat_ff[CRF_INT_WM])
    else $error("watermark flag not raised");
  // back-to-back stores keep the strobe high, else it drops
  AST_CAP: assert property (
    (store && cap_sel_ff) |=> o_cap_trigger ##1
    (!cap_sel_ff || (o_cap_trigger == ($past(store) && $past(cap_sel_ff)))))
    else $error("capture strobe not one cycle");
  AST_PIN: assert property (
    !cap_sel_ff |-> o_cap_trigger == cap_sync_ff)
    else $error("pin capture source not passed");
  AST_WRAP: assert property (
    (store && ({1'b0, wp_ff} + 4'h1 == fifo_len)) |=> wp_ff == 3'h0)
    else $error("write pointer did not wrap");

  COV_STORE: cover property (store ##1 rp_clear);
  COV_WRAP:  cover property (store && wp_ff == 3'h7);
  COV_OVF:   cover property (ovf);
  COV_WM:    cover property (wm_event && wm_sel_ff);

endmodule : crf_rx_fifo
`default_nettype wire

// >>> tb/crf_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module crf_engine_model
  import crf_pkg::*;
(
  // clock
  input  wire logic                  i_clk,
  // message side
  output logic                       o_msg_valid,
  output logic      [CRF_ID_W-1:0]   o_msg_id,
  output logic      [CRF_DLC_W-1:0]  o_msg_dlc,
  output logic      [CRF_DATA_W-1:0] o_msg_data,
  // capture unit
  input  wire logic                  i_cap_trigger,
  input  wire logic [3:0]            i_cap_mode,
  output logic      [15:0]           o_stamp,
  output logic      [7:0]            o_stamp_cnt
);
  logic [15:0] timer_ff;

  initial begin
    o_msg_valid = 1'b0;
    o_msg_id    = '0;
    o_msg_dlc   = '0;
    o_msg_data  = '0;
    o_stamp     = '0;
    o_stamp_cnt = '0;
    timer_ff    = '0;
  end

  // ***********************************************
  // capture unit: latch timer on can event trigger
  // ***********************************************
  always @(posedge i_clk) begin
    timer_ff <= timer_ff + 16'h0001;
    if (i_cap_trigger && (i_cap_mode == 4'h3)) begin
      o_stamp     <= timer_ff;
      o_stamp_cnt <= o_stamp_cnt + 8'h01;
    end
  end

  // one accepted-candidate message, lines scrambled when idle
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [63:0] data);
    @(posedge i_clk);
    o_msg_valid <= 1'b1;
    o_msg_id    <= id;
    o_msg_dlc   <= dlc;
    o_msg_data  <= data;
    @(posedge i_clk);
    o_msg_valid <= 1'b0;
    o_msg_id    <= ~id;
    o_msg_dlc   <= ~dlc;
    o_msg_data  <= ~data;
  endtask : send
endmodule : crf_engine_model
`default_nettype wire

// >>> tb/crf_rx_fifo_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module crf_rx_fifo_tb_top
  import crf_pkg::*;
;
  logic                  i_clk;
  logic                  i_rst_n;
  logic [7:0]            i_addr;
  logic [7:0]            i_wdata;
  logic                  i_wr;
  logic                  i_rd;
  logic [7:0]            o_rdata;
  logic                  msg_valid;
  logic [CRF_ID_W-1:0]   msg_id;
  logic [CRF_DLC_W-1:0]  msg_dlc;
  logic [CRF_DATA_W-1:0] msg_data;
  logic                  i_cap_pin;
  logic                  o_cap_trigger;
  logic                  o_fifo_empty;
  logic                  o_irq;
  logic [7:0]            stamp_cnt;
  int                    num_errors;
  int                    n_checks;

  crf_rx_fifo DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_msg_valid(msg_valid),
    .i_msg_id(msg_id), .i_msg_dlc(msg_dlc), .i_msg_data(msg_data),
    .i_cap_pin(i_cap_pin), .o_cap_trigger(o_cap_trigger),
    .o_fifo_empty(o_fifo_empty), .o_irq(o_irq)
  );

  crf_engine_model u_eng (
    .i_clk(i_clk), .o_msg_valid(msg_valid), .o_msg_id(msg_id),
    .o_msg_dlc(msg_dlc), .o_msg_data(msg_data),
    .i_cap_trigger(o_cap_trigger), .i_cap_mode(4'h3), .o_stamp(),
    .o_stamp_cnt(stamp_cnt)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ***********************************************
  // bus tasks and checks
  // ***********************************************
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    // return off the edge so callers see settled outputs
    @(negedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string name);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    chk(name, exp, o_rdata);
  endtask : rd

  task automatic pin(input string name, input logic exp, input logic got);
    @(negedge i_clk);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask : pin

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if ((num_errors == 0) && (n_checks > 0)) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6000) @(posedge i_clk);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end

  // ***********************************************
  // test sequence
  // ***********************************************
  initial begin
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cap_pin = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      rd(8'(a), 8'h00, "reset value");
    end
    pin("empty", 1'b1, o_fifo_empty);
    pin("irq", 1'b0, o_irq);
    wr(CRF_A_ENHANCED, 8'hff);
    rd(CRF_A_ENHANCED, 8'he0, "enhanced");
    wr(8'hff, 8'h5a);
    rd(8'hff, 8'h00, "unmapped");
    tend("registers");
    wr(CRF_A_ENHANCED, 8'h80);
    wr(CRF_A_FILT_BASE, 8'h24);
    wr(CRF_A_FILT_BASE + 8'h01, 8'h03);
    wr(CRF_A_FILT_BASE + 8'h02, 8'hff);
    wr(CRF_A_FILT_BASE + 8'h03, 8'h07);
    wr(CRF_A_FILTEN, 8'h01);
    wr(CRF_A_INTMASK, 8'h07);
    wr(CRF_A_IOCTRL, 8'h10);
    u_eng.send(11'h122, 4'h2, 64'h0);
    rd(CRF_A_FULL, 8'h00, "full after reject");
    u_eng.send(11'h123, 4'h8, 64'h8877665544332211);
    rd(CRF_A_FULL, 8'h01, "full after accept");
    rd(CRF_A_STATUS, 8'h10, "interrupt code");
    chk("stamp count", 8'h01, stamp_cnt);
    rd(CRF_A_ID_HI, 8'h24, "id high");
    rd(CRF_A_ID_LO, 8'h60, "id low");
    rd(CRF_A_DLC, 8'h08, "dlc");
    rd(8'h18, 8'h11, "data byte 0");
    rd(8'h1f, 8'h88, "data byte 7");
    pin("irq", 1'b1, o_irq);
    tend("accept");
    wr(CRF_A_FILTEN, 8'h03);
    u_eng.send(11'h555, 4'h1, 64'h5a);
    rd(CRF_A_FULL, 8'h03, "any filter");
    wr(CRF_A_FULL, 8'h01);
    rd(CRF_A_CONTROL, 8'h01, "read pointer");
    rd(CRF_A_FULL, 8'h02, "full after pop");
    wr(CRF_A_INTSTAT, 8'h07);
    rd(CRF_A_STATUS, 8'h00, "code cleared");
    pin("irq", 1'b0, o_irq);
    tend("pop");
    for (int i = 2; i < 8; i++) begin
      if (i == 5) begin
        wr(CRF_A_INTSTAT, 8'h07);
        wr(CRF_A_ENHANCED, 8'ha0);
      end
      u_eng.send(11'(i), 4'h1, 64'(i));
      rd(CRF_A_INTSTAT, ((i == 4) || (i == 7)) ? 8'h03 : 8'h01,
         "watermark");
    end
    u_eng.send(11'h7ff, 4'h1, 64'h0);
    rd(CRF_A_FULL, 8'hff, "wrap store");
    u_eng.send(11'h7fe, 4'h1, 64'h0);
    rd(CRF_A_INTSTAT, 8'h07, "overflow");
    rd(CRF_A_FULL, 8'hff, "full held");
    chk("stamp count", 8'h09, stamp_cnt);
    pin("empty", 1'b0, o_fifo_empty);
    tend("fill");
    wr(CRF_A_INTMASK, 8'h04);
    pin("irq", 1'b1, o_irq);
    wr(CRF_A_INTSTAT, 8'h04);
    pin("irq masked", 1'b0, o_irq);
    wr(CRF_A_INTMASK, 8'h03);
    pin("irq", 1'b1, o_irq);
    wr(CRF_A_INTSTAT, 8'h03);
    pin("irq", 1'b0, o_irq);
    tend("interrupt");
    for (int i = 1; i <= 8; i++) begin
      rd(CRF_A_CONTROL, 8'(i % 8), "read pointer");
      wr(CRF_A_FULL, 8'h01 << (i % 8));
    end
    rd(CRF_A_FULL, 8'h00, "drained");
    pin("empty", 1'b1, o_fifo_empty);
    tend("drain");
    wr(CRF_A_TXSEL, 8'h01);
    rd(CRF_A_TXSEL, 8'h01, "tx select");
    for (int i = 0; i < 3; i++) begin
      u_eng.send(11'h100, 4'h1, 64'h0);
    end
    rd(CRF_A_FULL, 8'h03, "length two");
    tend("length");
    wr(CRF_A_IOCTRL, 8'h00);
    @(posedge i_clk);
    i_cap_pin <= 1'b1;
    repeat (3) @(posedge i_clk);
    pin("pin capture", 1'b1, o_cap_trigger);
    @(posedge i_clk);
    i_cap_pin <= 1'b0;
    repeat (3) @(posedge i_clk);
    pin("pin capture", 1'b0, o_cap_trigger);
    tend("capture");
    wr(CRF_A_ENHANCED, 8'h00);
    wr(CRF_A_INTSTAT, 8'h07);
    u_eng.send(11'h100, 4'h1, 64'h0);
    rd(CRF_A_INTSTAT, 8'h00, "mode off status");
    rd(CRF_A_FULL, 8'h03, "mode off full");
    tend("mode");
    test_done();
  end
endmodule : crf_rx_fifo_tb_top
`default_nettype wire
